// ---- core/afe_pkg.sv ----
// Constants, field positions and carrier types for the front-end register bank.
// Assumes a single 50 MHz clock domain and a serial front end that issues word requests.
//
// Overview of operation
// - Every register is a separately addressable word of at most 24 bits.
// - Status width fields reformat the address-zero result.
// - Read/write grouping fields choose the looped address set.
// - Read-only result at address zero, MSB first.
// - Modulator output is read/write at 0x08.
// - Start delay register is mapped at 0x09.
// - Status/communication register is read/write at 0x0C.
// - Offset correction register is read/write at 0x0F.
// - Gain correction applied when its enable is set.
// - Security register holds password and map checksum.
// - Result held steady while a read is in progress.
// - Start delay write restarts the converter.
package afe_pkg;

    localparam int unsigned DATA_W = 24;
    localparam int unsigned ADDR_W = 5;

    // ****************************************************************
    // Register addresses.
    // ****************************************************************
    localparam logic [4:0] ADDR_RESULT  = 5'h00;
    localparam logic [4:0] ADDR_MOD     = 5'h08;
    localparam logic [4:0] ADDR_DELAY   = 5'h09;
    localparam logic [4:0] ADDR_GAIN    = 5'h0B;
    localparam logic [4:0] ADDR_STATUS  = 5'h0C;
    localparam logic [4:0] ADDR_SETUP_A = 5'h0D;
    localparam logic [4:0] ADDR_SETUP_B = 5'h0E;
    localparam logic [4:0] ADDR_OFFSET  = 5'h0F;
    localparam logic [4:0] ADDR_GCORR   = 5'h10;
    localparam logic [4:0] ADDR_SECURE  = 5'h1F;

    // ****************************************************************
    // Field positions and widths.
    // ****************************************************************
    localparam int unsigned MOD_W        = 4;
    localparam int unsigned DELAY_W      = 12;
    localparam int unsigned PGA_W        = 3;
    localparam int unsigned STAT_READ_HI = 23;
    localparam int unsigned STAT_READ_LO = 22;
    localparam int unsigned STAT_WRITE   = 21;
    localparam int unsigned STAT_WCRC    = 18;
    localparam int unsigned STAT_WDAT_HI = 17;
    localparam int unsigned STAT_WDAT_LO = 16;
    localparam int unsigned SETB_EN_OFF  = 1;
    localparam int unsigned SETB_EN_GAIN = 0;
    localparam int unsigned SEC_KEY_LO   = 16;
    localparam int unsigned CRC_W        = 16;

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [23:0] RST_MOD    = 24'h000003;
    localparam logic [23:0] RST_STATUS = 24'hA10000;
    localparam logic [23:0] RST_ZERO   = 24'h000000;

    // ****************************************************************
    // Encodings of the looping and width fields.
    // ****************************************************************
    localparam logic [1:0] LOOP_STATIC = 2'h0;
    localparam logic [1:0] LOOP_GROUP  = 2'h1;
    localparam logic [1:0] LOOP_TYPE   = 2'h2;
    localparam logic [1:0] LOOP_MAP    = 2'h3;
    localparam logic [1:0] FMT_16      = 2'h0;
    localparam logic [1:0] FMT_24      = 2'h1;
    localparam logic [1:0] FMT_32_ZERO = 2'h2;
    localparam logic [1:0] FMT_32_SIGN = 2'h3;

    typedef struct packed {
        logic [4:0]  addr;
        logic        wr;
        logic        rd;
        logic [23:0] wdata;
    } afe_req_t;

endpackage

// ---- core/afe_corr.sv ----
// Digital offset and gain correction of each new raw conversion.
// Assumes raw samples arrive as one-cycle valid pulses in the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module afe_corr #(
    parameter int unsigned W = 24
) (
    input  wire logic         ref_clk,  // System clock.
    input  wire logic         rst,      // Synchronous reset, active high.
    input  wire logic [W-1:0] raw,      // Raw two's complement sample.
    input  wire logic         raw_vld,  // Raw sample strobe.
    input  wire logic [W-1:0] offset,   // Offset correction word.
    input  wire logic [W-1:0] gain,     // Gain correction word, 1.23 signed fraction.
    input  wire logic         en_off,   // Offset correction enable.
    input  wire logic         en_gain,  // Gain correction enable.
    output logic      [W-1:0] corr,     // Corrected sample.
    output logic              corr_vld  // Corrected sample strobe.
);

    logic [W-1:0]   corr_ff;
    logic           vld_ff;
    wire  [W-1:0]   with_off = en_off ? W'(raw + offset) : raw;
    wire  [2*W-1:0] product  = (2*W)'($signed(with_off) * $signed(gain));
    wire  [W-1:0]   scaled   = product[2*W-2:W-1];
    wire  [W-1:0]   nxt_corr = en_gain ? W'(with_off + scaled) : with_off;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            corr_ff <= '0;
            vld_ff  <= 1'b0;
        end else begin
            vld_ff <= raw_vld;
            if (raw_vld) begin
                corr_ff <= nxt_corr;
            end
        end
    end

    assign corr     = corr_ff;
    assign corr_vld = vld_ff;

endmodule
`default_nettype wire

// ---- core/afe_regbank.sv ----
// Register bank of the single-channel front end, reached by word requests from the serial front end.
// Assumes the serial framing, checksum engine and converter sit outside and share ref_clk.
`timescale 1ns/1ps
`default_nettype none
module afe_regbank (
    input  wire logic              ref_clk,      // System clock, 50 MHz.
    input  wire logic              rst,          // Synchronous reset, active high.
    input  wire afe_pkg::afe_req_t req,          // Register request from the serial front end.
    input  wire logic              xfer_active,  // High while a result read transfer runs.
    input  wire logic [23:0]       adc_raw,      // Raw conversion from the converter.
    input  wire logic              adc_ready,    // Conversion strobe.
    input  wire logic [3:0]        mod_bits,     // Comparator outputs.
    input  wire logic              mod_update,   // Modulator clock enable.
    input  wire logic [15:0]       map_crc,      // Checksum over the register map.
    output logic      [31:0]       rd_data,      // Read answer.
    output logic                   rd_valid,     // Read answer strobe.
    output logic      [4:0]        next_addr,    // Next address of a looped transfer.
    output logic                   restart,      // Converter restart pulse.
    output logic      [11:0]       start_delay,  // Conversion start delay.
    output logic      [2:0]        pga_sel,      // Amplifier setting.
    output logic      [23:0]       setup_a,      // Converter setup word A.
    output logic      [23:0]       setup_b,      // Converter setup word B.
    output logic                   crc_wide      // Checksum width select.
);

    // ****************************************************************
    // Storage.
    // ****************************************************************
    logic [23:0] result_ff, pend_ff, status_ff, setup_a_ff, setup_b_ff;
    logic [23:0] offset_ff, gcorr_ff;
    logic [3:0]  mod_ff;
    logic [11:0] delay_ff;
    logic [2:0]  pga_ff;
    logic [7:0]  key_ff;
    logic        pend_new_ff;
    logic [31:0] rd_data_ff;
    logic        rd_valid_ff;
    logic        restart_ff;
    logic [4:0]  next_addr_ff;
    logic [23:0] corr;
    logic        corr_vld;

    afe_corr #(.W(afe_pkg::DATA_W)) u_corr (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .raw      (adc_raw),
        .raw_vld  (adc_ready),
        .offset   (offset_ff),
        .gain     (gcorr_ff),
        .en_off   (setup_b_ff[afe_pkg::SETB_EN_OFF]),
        .en_gain  (setup_b_ff[afe_pkg::SETB_EN_GAIN]),
        .corr     (corr),
        .corr_vld (corr_vld)
    );

    // ****************************************************************
    // Decoding.
    // ****************************************************************
    wire [1:0] read_loop  = status_ff[afe_pkg::STAT_READ_HI:afe_pkg::STAT_READ_LO];
    wire       write_loop = status_ff[afe_pkg::STAT_WRITE];
    wire [1:0] width_sel  = status_ff[afe_pkg::STAT_WDAT_HI:afe_pkg::STAT_WDAT_LO];
    wire       wr_mod     = req.wr && (req.addr == afe_pkg::ADDR_MOD);
    wire       wr_delay   = req.wr && (req.addr == afe_pkg::ADDR_DELAY);
    wire       take_pend  = pend_new_ff && !xfer_active;
    logic [31:0] rd_mux;
    logic [4:0]  lo_addr, hi_addr;
    wire  [4:0]  nxt_next = (req.addr == hi_addr) ? lo_addr : 5'(req.addr + 5'h01);

    // Address zero carries the result in the selected width.
    always_comb begin
        if (req.addr == afe_pkg::ADDR_RESULT) begin
            if (width_sel == afe_pkg::FMT_16) begin
                rd_mux = {16'h0000, result_ff[23:8]};
            end else if (width_sel == afe_pkg::FMT_24) begin
                rd_mux = {8'h00, result_ff};
            end else if (width_sel == afe_pkg::FMT_32_ZERO) begin
                rd_mux = {result_ff, 8'h00};
            end else begin
                rd_mux = {{8{result_ff[23]}}, result_ff};
            end
        end else if (req.addr == afe_pkg::ADDR_MOD) begin
            rd_mux = {28'h0000000, mod_ff};
        end else if (req.addr == afe_pkg::ADDR_DELAY) begin
            rd_mux = {20'h00000, delay_ff};
        end else if (req.addr == afe_pkg::ADDR_GAIN) begin
            rd_mux = {29'h0000000, pga_ff};
        end else if (req.addr == afe_pkg::ADDR_STATUS) begin
            rd_mux = {8'h00, status_ff};
        end else if (req.addr == afe_pkg::ADDR_SETUP_A) begin
            rd_mux = {8'h00, setup_a_ff};
        end else if (req.addr == afe_pkg::ADDR_SETUP_B) begin
            rd_mux = {8'h00, setup_b_ff};
        end else if (req.addr == afe_pkg::ADDR_OFFSET) begin
            rd_mux = {8'h00, offset_ff};
        end else if (req.addr == afe_pkg::ADDR_GCORR) begin
            rd_mux = {8'h00, gcorr_ff};
        end else if (req.addr == afe_pkg::ADDR_SECURE) begin
            rd_mux = {8'h00, key_ff, map_crc};
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    // Looped address set: the read field on reads, the write bit on writes.
    always_comb begin
        lo_addr = req.addr;
        hi_addr = req.addr;
        if (req.wr && write_loop && req.addr >= afe_pkg::ADDR_MOD) begin
            lo_addr = afe_pkg::ADDR_MOD;
            hi_addr = afe_pkg::ADDR_SECURE;
        end else if (req.rd && read_loop == afe_pkg::LOOP_MAP) begin
            lo_addr = afe_pkg::ADDR_RESULT;
            hi_addr = afe_pkg::ADDR_SECURE;
        end else if (req.rd && read_loop == afe_pkg::LOOP_TYPE && req.addr >= afe_pkg::ADDR_MOD) begin
            lo_addr = afe_pkg::ADDR_MOD;
            hi_addr = afe_pkg::ADDR_SECURE;
        end else if (req.rd && read_loop == afe_pkg::LOOP_GROUP && req.addr >= afe_pkg::ADDR_MOD) begin
            if (req.addr <= afe_pkg::ADDR_SETUP_B) begin
                lo_addr = afe_pkg::ADDR_MOD;
                hi_addr = afe_pkg::ADDR_SETUP_B;
            end else if (req.addr <= afe_pkg::ADDR_GCORR) begin
                lo_addr = afe_pkg::ADDR_OFFSET;
                hi_addr = afe_pkg::ADDR_GCORR;
            end
        end
    end

    // ****************************************************************
    // Writable registers.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_ff  <= afe_pkg::RST_STATUS;
            setup_a_ff <= afe_pkg::RST_ZERO;
            setup_b_ff <= afe_pkg::RST_ZERO;
            offset_ff  <= afe_pkg::RST_ZERO;
            gcorr_ff   <= afe_pkg::RST_ZERO;
            delay_ff   <= '0;
            pga_ff     <= '0;
            key_ff     <= '0;
        end else if (req.wr) begin
            if (req.addr == afe_pkg::ADDR_DELAY) begin
                delay_ff <= req.wdata[11:0];
            end else if (req.addr == afe_pkg::ADDR_GAIN) begin
                pga_ff <= req.wdata[2:0];
            end else if (req.addr == afe_pkg::ADDR_STATUS) begin
                status_ff <= req.wdata;
            end else if (req.addr == afe_pkg::ADDR_SETUP_A) begin
                setup_a_ff <= req.wdata;
            end else if (req.addr == afe_pkg::ADDR_SETUP_B) begin
                setup_b_ff <= req.wdata;
            end else if (req.addr == afe_pkg::ADDR_OFFSET) begin
                offset_ff <= req.wdata;
            end else if (req.addr == afe_pkg::ADDR_GCORR) begin
                gcorr_ff <= req.wdata;
            end else if (req.addr == afe_pkg::ADDR_SECURE) begin
                key_ff <= req.wdata[23:16];
            end
        end
    end

    // Modulator bits: software write wins over a same-cycle update.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mod_ff <= afe_pkg::RST_MOD[3:0];
        end else if (wr_mod) begin
            mod_ff <= req.wdata[3:0];
        end else if (mod_update) begin
            mod_ff <= mod_bits;
        end
    end

    // ****************************************************************
    // Result latch and answers.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result_ff   <= '0;
            pend_ff     <= '0;
            pend_new_ff <= 1'b0;
        end else begin
            if (corr_vld) begin
                pend_ff <= corr;
            end
            pend_new_ff <= corr_vld || (pend_new_ff && xfer_active);
            if (take_pend) begin
                result_ff <= pend_ff;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data_ff   <= '0;
            rd_valid_ff  <= 1'b0;
            restart_ff   <= 1'b0;
            next_addr_ff <= '0;
        end else begin
            rd_valid_ff <= req.rd;
            restart_ff  <= wr_delay;
            if (req.rd) begin
                rd_data_ff <= rd_mux;
            end
            if (req.rd || req.wr) begin
                next_addr_ff <= nxt_next;
            end
        end
    end

    assign rd_data     = rd_data_ff;
    assign rd_valid    = rd_valid_ff;
    assign next_addr   = next_addr_ff;
    assign restart     = restart_ff;
    assign start_delay = delay_ff;
    assign pga_sel     = pga_ff;
    assign setup_a     = setup_a_ff;
    assign setup_b     = setup_b_ff;
    assign crc_wide    = status_ff[afe_pkg::STAT_WCRC];

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    property p_unused_zero;
        @(posedge ref_clk) disable iff (rst)
        (req.rd && req.addr == 5'h05) |=> (rd_valid && rd_data == 32'h00000000);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused address did not read zero");

    property p_restart;
        @(posedge ref_clk) disable iff (rst)
        (req.wr && req.addr == 5'h09) |=> restart ##1 !restart || (req.wr && req.addr == 5'h09);
    endproperty
    a_restart: assert property (p_restart) else $error("delay write gave no restart pulse");

    property p_no_restart;
        @(posedge ref_clk) disable iff (rst)
        !(req.wr && req.addr == 5'h09) |=> !restart;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("spurious restart");

    property p_hold_in_xfer;
        @(posedge ref_clk) disable iff (rst)
        (xfer_active && $past(xfer_active)) |-> $stable(result_ff);
    endproperty
    a_hold_in_xfer: assert property (p_hold_in_xfer) else $error("result changed during read");

    property p_result_24;
        @(posedge ref_clk) disable iff (rst)
        (req.rd && req.addr == 5'h00 && width_sel == 2'h1) |=> rd_data == {8'h00, $past(result_ff)};
    endproperty
    a_result_24: assert property (p_result_24) else $error("24-bit result format wrong");

    property p_result_16;
        @(posedge ref_clk) disable iff (rst)
        (req.rd && req.addr == 5'h00 && width_sel == 2'h0) |=> rd_data[31:16] == 16'h0000;
    endproperty
    a_result_16: assert property (p_result_16) else $error("16-bit result format wrong");

    property p_offset_rw;
        @(posedge ref_clk) disable iff (rst)
        (req.wr && req.addr == 5'h0F) ##1 (!req.wr && !req.rd) ##1 (req.rd && req.addr == 5'h0F && !req.wr)
            |=> rd_data[23:0] == $past(req.wdata, 3);
    endproperty
    a_offset_rw: assert property (p_offset_rw) else $error("offset register readback wrong");

    property p_status_rw;
        @(posedge ref_clk) disable iff (rst)
        (req.wr && req.addr == 5'h0C) |=> status_ff == $past(req.wdata);
    endproperty
    a_status_rw: assert property (p_status_rw) else $error("status register not written");

    property p_secure_crc;
        @(posedge ref_clk) disable iff (rst)
        (req.rd && req.addr == 5'h1F) |=> rd_data[15:0] == $past(map_crc);
    endproperty
    a_secure_crc: assert property (p_secure_crc) else $error("checksum not shown in security word");

    property p_mod_write;
        @(posedge ref_clk) disable iff (rst)
        (req.wr && req.addr == 5'h08) |=> mod_ff == $past(req.wdata[3:0]);
    endproperty
    a_mod_write: assert property (p_mod_write) else $error("modulator register not written");

    property p_rd_valid;
        @(posedge ref_clk) disable iff (rst)
        req.rd |=> rd_valid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read gave no answer strobe");

    c_held_sample: cover property (@(posedge ref_clk) disable iff (rst) corr_vld && xfer_active ##[1:20] take_pend);
    c_delay_write: cover property (@(posedge ref_clk) disable iff (rst) restart);
    c_loop_wrap: cover property (@(posedge ref_clk) disable iff (rst) req.rd && req.addr == 5'h1F && read_loop == 2'h3);

endmodule
`default_nettype wire

// ---- test/afe_conv_model.sv ----
// Converter-side model that feeds samples, modulator bits and the map checksum.
// Assumes the bench calls its tasks at the falling edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module afe_conv_model #(
    parameter logic [15:0] CRC = 16'h5A3C  // Checksum presented to the bank.
) (
    input  wire logic        ref_clk,     // System clock.
    output logic      [23:0] adc_raw,     // Raw sample.
    output logic             adc_ready,   // Sample strobe.
    output logic      [3:0]  mod_bits,    // Comparator outputs.
    output logic             mod_update,  // Modulator enable.
    output logic      [15:0] map_crc      // Map checksum.
);
    initial begin
        adc_raw    = 24'h000000;
        adc_ready  = 1'b0;
        mod_bits   = 4'h0;
        mod_update = 1'b0;
        map_crc    = CRC;
    end

    // Between strobes the buses show the inverse, so a late capture is caught.
    task automatic fire(input logic [23:0] v);
        @(negedge ref_clk);
        adc_raw   = v;
        adc_ready = 1'b1;
        @(negedge ref_clk);
        adc_raw   = ~v;
        adc_ready = 1'b0;
    endtask

    task automatic pulse_mod(input logic [3:0] b);
        @(negedge ref_clk);
        mod_bits   = b;
        mod_update = 1'b1;
        @(negedge ref_clk);
        mod_bits   = ~b;
        mod_update = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- test/afe_register_map_tb.sv ----
// Self-checking bench of the register bank with a converter model beside it.
// Assumes the design package and bank are compiled first.
`timescale 1ns/1ps
`default_nettype none
module afe_register_map_tb;
    localparam logic [15:0] CRC = 16'h5A3C;
    logic              ref_clk, rst, xfer_active, adc_ready, mod_update, rd_valid, restart, crc_wide;
    afe_pkg::afe_req_t req;
    logic [23:0]       adc_raw, setup_a, setup_b;
    logic [3:0]        mod_bits;
    logic [15:0]       map_crc;
    logic [31:0]       rd_data, got;
    logic [4:0]        next_addr;
    logic [11:0]       start_delay;
    logic [2:0]        pga_sel;
    int                fails, comparisons;

    afe_regbank i_afe_regbank (.ref_clk(ref_clk), .rst(rst), .req(req), .xfer_active(xfer_active),
        .adc_raw(adc_raw), .adc_ready(adc_ready), .mod_bits(mod_bits), .mod_update(mod_update),
        .map_crc(map_crc), .rd_data(rd_data), .rd_valid(rd_valid), .next_addr(next_addr),
        .restart(restart), .start_delay(start_delay), .pga_sel(pga_sel), .setup_a(setup_a),
        .setup_b(setup_b), .crc_wide(crc_wide));
    afe_conv_model #(.CRC(CRC)) i_afe_conv_model (.ref_clk(ref_clk), .adc_raw(adc_raw),
        .adc_ready(adc_ready), .mod_bits(mod_bits), .mod_update(mod_update), .map_crc(map_crc));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic rd(input logic [4:0] a);
        @(negedge ref_clk);
        req.addr = a;
        req.rd   = 1'b1;
        @(negedge ref_clk);
        req.rd = 1'b0;
        chk({31'h0, rd_valid}, 32'h1);
        got = rd_data;
    endtask

    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(negedge ref_clk);
        req.addr  = a;
        req.wdata = d;
        req.wr    = 1'b1;
        @(negedge ref_clk);
        req.wr = 1'b0;
    endtask

    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        rd(a);
        chk(got, e);
    endtask

    task automatic na(input logic [4:0] e);
        chk({27'h0, next_addr}, {27'h0, e});
    endtask

    task automatic set_stat(input logic [1:0] rm, input logic wb, input logic [1:0] fmt, input logic crc);
        wr(afe_pkg::ADDR_STATUS, {rm, wb, 2'b00, crc, fmt, 16'h0000});
    endtask

    task automatic t_reset();
        na(5'h00);
        chk(rd_data, 32'h00000000);
        chk({31'h0, rd_valid}, 32'h0);
        chk({16'h0, crc_wide, pga_sel, start_delay}, 32'h0);
        chk({8'h00, setup_a}, 32'h0);
        chk({8'h00, setup_b}, 32'h0);
        rchk(afe_pkg::ADDR_STATUS, 32'h00A10000);
        rchk(afe_pkg::ADDR_MOD, 32'h00000003);
        rchk(afe_pkg::ADDR_SECURE, {16'h0000, CRC});
    endtask

    task automatic t_access();
        logic [4:0]  a [11] = '{5'h0B, 5'h0D, 5'h0F, 5'h10, 5'h1F, 5'h08, 5'h00, 5'h01, 5'h0A, 5'h11, 5'h1E};
        logic [23:0] d [11] = '{24'hFFFFFF, 24'hA5C3E1, 24'h123456, 24'h654321, 24'hFFFFFF, 24'hFFFFFF,
                                24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF};
        logic [23:0] e [11] = '{24'h000007, 24'hA5C3E1, 24'h123456, 24'h654321, {8'hFF, CRC}, 24'h00000F,
                                24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
        for (int i = 0; i < 11; i++) begin
            wr(a[i], d[i]);
            rchk(a[i], {8'h00, e[i]});
        end
        chk({29'h0, pga_sel}, 32'h7);
        chk({8'h00, setup_a}, 32'h00A5C3E1);
        wr(afe_pkg::ADDR_DELAY, 24'hFFFFFF);
        chk({31'h0, restart}, 32'h1);
        @(negedge ref_clk);
        chk({31'h0, restart}, 32'h0);
        chk({20'h0, start_delay}, 32'h00000FFF);
        rchk(afe_pkg::ADDR_DELAY, 32'h00000FFF);
        i_afe_conv_model.pulse_mod(4'hA);
        rchk(afe_pkg::ADDR_MOD, 32'h0000000A);
    endtask

    task automatic t_format();
        logic [31:0] e [4] = '{32'h00008123, 32'h00812345, 32'h81234500, 32'hFF812345};
        i_afe_conv_model.fire(24'h812345);
        repeat (3) @(negedge ref_clk);
        for (int f = 0; f < 4; f++) begin
            set_stat(2'b10, 1'b1, f[1:0], 1'b0);
            rchk(afe_pkg::ADDR_RESULT, e[f]);
        end
        set_stat(2'b10, 1'b1, 2'b01, 1'b1);
        chk({31'h0, crc_wide}, 32'h1);
        set_stat(2'b10, 1'b1, 2'b01, 1'b0);
        chk({31'h0, crc_wide}, 32'h0);
    endtask

    task automatic t_latch();
        @(negedge ref_clk);
        xfer_active = 1'b1;
        i_afe_conv_model.fire(24'h0ABCDE);
        repeat (5) @(negedge ref_clk);
        rchk(afe_pkg::ADDR_RESULT, 32'h00812345);
        xfer_active = 1'b0;
        repeat (3) @(negedge ref_clk);
        rchk(afe_pkg::ADDR_RESULT, 32'h000ABCDE);
    endtask

    task automatic t_corr();
        wr(afe_pkg::ADDR_OFFSET, 24'h000010);
        wr(afe_pkg::ADDR_GCORR, 24'h400000);
        wr(afe_pkg::ADDR_SETUP_B, 24'h000001);
        chk({8'h00, setup_b}, 32'h00000001);
        i_afe_conv_model.fire(24'h100000);
        repeat (3) @(negedge ref_clk);
        rchk(afe_pkg::ADDR_RESULT, 32'h00180000);
        wr(afe_pkg::ADDR_SETUP_B, 24'h000002);
        i_afe_conv_model.fire(24'h100000);
        repeat (3) @(negedge ref_clk);
        rchk(afe_pkg::ADDR_RESULT, 32'h00100010);
    endtask

    task automatic t_loop();
        rd(5'h1F);
        na(5'h08);
        set_stat(2'b11, 1'b0, 2'b01, 1'b0);
        rd(5'h1F);
        na(5'h00);
        rd(5'h05);
        na(5'h06);
        set_stat(2'b01, 1'b0, 2'b01, 1'b0);
        rd(5'h0E);
        na(5'h08);
        rd(5'h10);
        na(5'h0F);
        set_stat(2'b00, 1'b0, 2'b01, 1'b0);
        rd(5'h0D);
        na(5'h0D);
        wr(5'h0B, 24'h000000);
        na(5'h0B);
        set_stat(2'b00, 1'b1, 2'b01, 1'b0);
        wr(5'h1F, 24'h000000);
        na(5'h08);
    endtask

    initial begin
        #100000;
        fails++;
        test_done();
    end

    initial begin
        fails       = 0;
        comparisons = 0;
        rst         = 1'b1;
        xfer_active = 1'b0;
        req         = '0;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_access();
        t_format();
        t_latch();
        t_corr();
        t_loop();
        test_done();
    end
endmodule
`default_nettype wire
